//--- common/ivi_map.svh
// register offsets, field positions and timing constants of the host
`ifndef IVI_MAP_SVH
`define IVI_MAP_SVH

// ----------------------------------------------------------------------
// apb offsets
// ----------------------------------------------------------------------
`define IVI_OFF_CMD    8'h00
`define IVI_OFF_INIT   8'h04
`define IVI_OFF_MASK   8'h08
`define IVI_OFF_STAT   8'h0c
`define IVI_OFF_VEC    8'h10

// ----------------------------------------------------------------------
// command codes and fields
// ----------------------------------------------------------------------
`define IVI_CMD_FLD    1:0
`define IVI_CMD_INIT   2'h0
`define IVI_CMD_MASKWR 2'h1
`define IVI_CMD_ACK    2'h2
`define IVI_CMD_MASKRD 2'h3
`define IVI_CFG_W1     7:0
`define IVI_CFG_BASE   15:8
`define IVI_CFG_CASC   23:16
`define IVI_CFG_MODES  31:24
`define IVI_W1_IC4     0
`define IVI_W1_SINGLE_DEVICE_FLAG    1
`define IVI_W1_ADI     2
`define IVI_W1_LEVEL_TRIGGER_SEL    3
`define IVI_W1_INIT    4
`define IVI_MD_UPM     0
`define IVI_MD_AUTO_END_OF_IRQ    1
`define IVI_MD_MS      2
`define IVI_MD_BUF     3
`define IVI_MD_SPECIAL_NESTING_EN    4
`define IVI_ST_BUSY    0
`define IVI_ST_DONE    1
`define IVI_ST_VERR    2
`define IVI_ST_IRQ     3
`define IVI_ST_MASK    15:8
`define IVI_VEC_B0     7:0
`define IVI_VEC_B1     15:8
`define IVI_VEC_B2     23:16
`define IVI_CALL_OP    8'hcd
`define IVI_ACK_PTR    2'h1
`define IVI_ACK_CALL   2'h2

// ----------------------------------------------------------------------
// strobe timing
// ----------------------------------------------------------------------
`define IVI_CLK_NS     8
`define IVI_STROBE_NS  240
`define IVI_RECOV_NS   200
`define IVI_STROBE_CYC ((`IVI_STROBE_NS + `IVI_CLK_NS - 1) / `IVI_CLK_NS)
`define IVI_RECOV_CYC  ((`IVI_RECOV_NS + `IVI_CLK_NS - 1) / `IVI_CLK_NS)

`endif

//--- common/ivi_pkg.sv
// types shared by the host controller modules
package ivi_pkg;
	typedef enum logic [1:0] {kWrite, kRead, kAck} ivi_kind_t;
	typedef enum logic [1:0] {phIdle, phSetup, phStrobe, phRecov} ivi_phase_t;
	typedef enum logic [2:0] {
		stIdle, stWord1, stWord2, stCascade, stModes,
		stMaskWr, stMaskRd, stAck
	} ivi_state_t;
endpackage

//--- testbench/interrupt_vector_and_init_words_bench.sv
// self-checking bench for the apb host of the interrupt device
`include "ivi_map.svh"
`define CHK(nm, e, g) \
	begin \
		nCompared++; \
		if ((g) !== (e)) begin \
			errTotal++; \
			$display("Error %s expected %h seen %h", nm, e, g); \
		end \
	end
module interrupt_vector_and_init_words_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr, dataOut, dataIn, devData, reqLine, busLast;
	logic [31:0] pwdata, prdata, rd;
	logic        chipSelB, writeB, readB, irqAckStrobeB, cmdSelectAddr;
	logic        dataOe, devOe, devIrq;
	int          errTotal = 0;
	int          nCompared = 0;
	int          cycles = 0;

	ivi_host #(.STROBE_CYC(3), .RECOV_CYC(2)) ivi_host_inst (
		.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .chipSelB, .writeB, .readB, .irqAckStrobeB,
		.cmdSelectAddr, .dataOut, .dataOe, .dataIn, .devIrq
	);
	ivi_dev_model ivi_dev_model_inst (
		.chipSelB, .writeB, .readB, .irqAckStrobeB, .cmdSelectAddr,
		.busIn(dataIn), .requestInput(reqLine), .devData, .devOe, .devIrq
	);
	// undriven bus changes every cycle
	assign dataIn = dataOe ? dataOut : (devOe ? devData : ~busLast);
	always @(posedge clk) busLast <= dataIn;
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errTotal++;
			complete_run();
		end
	end
	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic st();
		apb(1'b0, `IVI_OFF_STAT, 32'h0);
	endtask
	task automatic cmd(input logic [1:0] c);
		apb(1'b1, `IVI_OFF_CMD, {30'h0, c});
		repeat (3) @(posedge clk);
		do
			st();
		while (rd[`IVI_ST_BUSY] !== 1'b0);
	endtask
	task automatic setup(input logic [31:0] cfg);
		apb(1'b1, `IVI_OFF_INIT, cfg);
		cmd(`IVI_CMD_INIT);
	endtask
	task automatic maskWr(input logic [7:0] m);
		apb(1'b1, `IVI_OFF_MASK, {24'h0, m});
		cmd(`IVI_CMD_MASKWR);
	endtask
	task automatic ack();
		cmd(`IVI_CMD_ACK);
		apb(1'b0, `IVI_OFF_VEC, 32'h0);
	endtask
	task automatic pulse(input logic [7:0] r);
		@(posedge clk);
		reqLine <= 8'h00;
		@(posedge clk);
		reqLine <= r;
	endtask
	task automatic complete_run();
		if (errTotal == 0 && nCompared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		{clk, rst_b, psel, penable, pwrite, paddr, pwdata, reqLine} = '0;
		busLast = 8'h00;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		st();
		`CHK("status", 32'h0, rd)
		apb(1'b0, 8'h14, 32'h0);
		`CHK("slverr", 1'b1, er)
		ack();
		`CHK("refused", 32'h0, rd)
		setup(32'h00003ca6);
		`CHK("done", 1'b1, rd[`IVI_ST_DONE])
		maskWr(8'h5a);
		cmd(`IVI_CMD_MASKRD);
		`CHK("mask", 8'h5a, rd[`IVI_ST_MASK])
		reqLine <= 8'h20;
		setup(32'h00003ca6);
		cmd(`IVI_CMD_MASKRD);
		`CHK("mask", 8'h00, rd[`IVI_ST_MASK])
		st();
		`CHK("irq", 1'b0, rd[`IVI_ST_IRQ])
		pulse(8'h20);
		repeat (4) @(posedge clk);
		st();
		`CHK("irq", 1'b1, rd[`IVI_ST_IRQ])
		maskWr(8'h20);
		st();
		`CHK("irq", 1'b0, rd[`IVI_ST_IRQ])
		maskWr(8'h00);
		ack();
		`CHK("vector", 24'h3cb4cd, rd[23:0])
		st();
		`CHK("verr", 1'b0, rd[`IVI_ST_VERR])
		setup(32'h00003ca2);
		pulse(8'h20);
		ack();
		`CHK("vector", 24'h3ca8cd, rd[23:0])
		reqLine <= 8'h24;
		setup(32'h01003cab);
		st();
		`CHK("irq", 1'b1, rd[`IVI_ST_IRQ])
		maskWr(8'h04);
		ack();
		`CHK("pointer", 8'h3d, rd[15:8])
		st();
		`CHK("verr", 1'b0, rd[`IVI_ST_VERR])
		setup(32'h05005cac);
		ack();
		`CHK("vector", 24'h5ca8cd, rd[23:0])
		ack();
		`CHK("nested", 24'h5cbccd, rd[23:0])
		setup(32'h02005cad);
		ack();
		ack();
		`CHK("auto end", 24'h5ca8cd, rd[23:0])
		setup(32'h08015cad);
		ack();
		st();
		`CHK("slave", 1'b1, rd[`IVI_ST_VERR])
		complete_run();
	end
endmodule

//--- testbench/ivi_dev_model.sv
// behavioural model of the eight-level interrupt device behind the host
`include "ivi_map.svh"
module ivi_dev_model #(
	parameter logic [2:0] CAS_IN = 3'h0
) (
	input  wire logic       chipSelB,
	input  wire logic       writeB,
	input  wire logic       readB,
	input  wire logic       irqAckStrobeB,
	input  wire logic       cmdSelectAddr,
	input  wire logic [7:0] busIn,
	input  wire logic [7:0] requestInput,
	output logic [7:0]      devData,
	output logic            devOe,
	output logic            devIrq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] w1, base, casc, modes, maskBits, isrBits, edgeSeen, reqPrev;
	logic [7:0] wrData, pend, modesEff, low;
	logic       wrSel, wrA0, initDone, cpuMode, isMaster, drives;
	logic [2:0] lvl;
	int         nxt, ackCnt, svc;

	initial begin
		{w1, base, casc, modes, maskBits, isrBits, edgeSeen, reqPrev} = '0;
		{devData, devOe, initDone, lvl} = '0;
		nxt = 0;
		ackCnt = 0;
	end
	// ----------------------------------------------------------------
	// decoded modes
	// ----------------------------------------------------------------
	assign modesEff = w1[0] ? modes : 8'h00;
	assign cpuMode = modesEff[0];
	assign isMaster = modesEff[3] ? modesEff[2] : 1'b1;
	assign pend = w1[3] ? requestInput : edgeSeen;
	assign devIrq = initDone & |(pend & ~maskBits);
	assign low = w1[2] ? {w1[7:5], lvl, 2'b00}
		: {w1[7:6], lvl, 3'b000};
	assign drives = isMaster ? !(!w1[1] && casc[lvl])
		: casc[2:0] == CAS_IN;

	// fresh rising edge needed per request in edge mode
	always @(requestInput) begin
		edgeSeen = (edgeSeen | (requestInput & ~reqPrev)) & requestInput;
		reqPrev = requestInput;
	end
	// ----------------------------------------------------------------
	// command words
	// ----------------------------------------------------------------
	always @(negedge writeB) begin
		wrSel = !chipSelB;
		wrA0 = cmdSelectAddr;
		wrData = busIn;
	end
	always @(posedge writeB) if (wrSel) begin
		if (!wrA0 && wrData[4]) begin
			w1 = wrData;
			{maskBits, isrBits, edgeSeen, modes} = '0;
			initDone = 1'b0;
			nxt = 1;
		end else if (wrA0 && nxt == 1) begin
			base = wrData;
			nxt = w1[1] ? (w1[0] ? 3 : 0) : 2;
		end else if (wrA0 && nxt == 2) begin
			casc = wrData;
			nxt = w1[0] ? 3 : 0;
		end else if (wrA0 && nxt == 3) begin
			modes = wrData;
			nxt = 0;
		end else if (wrA0 && initDone) begin
			maskBits = wrData;
		end
		initDone = initDone | (nxt == 0 && w1[4]);
	end
	// ----------------------------------------------------------------
	// acknowledge and status read
	// ----------------------------------------------------------------
	always @(negedge irqAckStrobeB) begin
		ackCnt++;
		if (ackCnt == 1) begin
			svc = 8;
			for (int i = 7; i >= 0; i--)
				if (isrBits[i])
					svc = i;
			// in-service level shuts out lower levels, and itself unless modesEff[4] is set
			lvl = 3'h7;
			for (int i = 7; i >= 0; i--)
				if (pend[i] && !maskBits[i] &&
					(i < svc || (modesEff[4] && i == svc)))
					lvl = 3'(i);
			isrBits[lvl] = 1'b1;
			edgeSeen[lvl] = 1'b0;
		end
		if (cpuMode) begin
			devData = {base[7:3], lvl};
			devOe = ackCnt == 2 && drives;
		end else begin
			devData = ackCnt == 1 ? `IVI_CALL_OP : low;
			if (ackCnt == 3)
				devData = base;
			devOe = (ackCnt == 1 && isMaster) || (ackCnt > 1 && drives);
		end
	end
	always @(posedge irqAckStrobeB) begin
		devOe = 1'b0;
		if (ackCnt == (cpuMode ? 2 : 3)) begin
			ackCnt = 0;
			if (modesEff[1])
				isrBits[lvl] = 1'b0;
		end
	end
	always @(negedge readB) if (!chipSelB) begin
		devData = cmdSelectAddr ? maskBits : pend;
		devOe = 1'b1;
	end
	always @(posedge readB) devOe = 1'b0;
endmodule

//--- verilog/ivi_host.sv
// apb-controlled host that initialises and acknowledges the device
//
// The APB interface to the registers was decided locally.
`include "ivi_map.svh"
module ivi_host
	import ivi_pkg::*;
#(
	parameter int STROBE_CYC = `IVI_STROBE_CYC,
	parameter int RECOV_CYC  = `IVI_RECOV_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             chipSelB,
	output logic             writeB,
	output logic             readB,
	output logic             irqAckStrobeB,
	output logic             cmdSelectAddr,
	output logic [7:0]       dataOut,
	output logic             dataOe,
	input  wire logic [7:0]  dataIn,
	input  wire logic        devIrq
);
	logic        rstS1Q, rstNQ, irqS1Q, irqS2Q;
	ivi_state_t  stateQ, stateD;
	logic        issuedQ, issuedD, initDoneQ, initDoneD, vecErrQ, vecErrD;
	logic [1:0]  ackIdxQ, ackIdxD;
	logic [31:0] cfgQ, cfgD, prdataQ, prdataD;
	logic [7:0]  maskQ, maskD, maskRdQ, maskRdD;
	logic [23:0] vecQ, vecD;
	logic        preadyQ, preadyD, slvErrQ, slvErrD;
	logic        wrEn, mapped, start, addrBit, sDone, ptrMode;
	ivi_kind_t   kind;
	logic [7:0]  wdata, sData, modesEff, w1, base;
	logic [1:0]  lastAck;

	// ------------------------------------------------------------------
	// reset release and irq synchroniser
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstS1Q <= 1'b0;
			rstNQ  <= 1'b0;
		end else begin
			rstS1Q <= 1'b1;
			rstNQ  <= rstS1Q;
		end
	end

	always_ff @(posedge clk or negedge rstNQ) begin
		if (!rstNQ) begin
			irqS1Q <= 1'b0;
			irqS2Q <= 1'b0;
		end else begin
			irqS1Q <= devIrq;
			irqS2Q <= irqS1Q;
		end
	end

	// ------------------------------------------------------------------
	// derived modes
	// ------------------------------------------------------------------
	assign w1       = cfgQ[`IVI_CFG_W1];
	assign base     = cfgQ[`IVI_CFG_BASE];
	assign modesEff = w1[`IVI_W1_IC4] ? cfgQ[`IVI_CFG_MODES] : 8'h00;
	assign ptrMode  = modesEff[`IVI_MD_UPM];
	assign lastAck  = ptrMode ? `IVI_ACK_PTR : `IVI_ACK_CALL;
	assign start    = (stateQ != stIdle) && !issuedQ;

	// expected content of each acknowledge byte
	function automatic logic byteOk(input logic [1:0] idx,
		input logic [7:0] b);
		byteOk = 1'b1;
		if (ptrMode) begin
			if (idx == 2'h1)
				byteOk = (b[7:3] == base[7:3]);
		end else if (idx == 2'h0) begin
			byteOk = (b == `IVI_CALL_OP);
		end else if (idx == 2'h1) begin
			if (w1[`IVI_W1_ADI])
				byteOk = (b[7:5] == w1[7:5]) && (b[1:0] == 2'h0);
			else
				byteOk = (b[7:6] == w1[7:6]) && (b[2:0] == 3'h0);
		end else begin
			byteOk = (b == base);
		end
	endfunction

	// ------------------------------------------------------------------
	// pin cycle request per state
	// ------------------------------------------------------------------
	always_comb begin
		kind    = kWrite;
		addrBit = 1'b1;
		wdata   = 8'h00;
		unique case (stateQ)
			stIdle:    wdata = 8'h00;
			stWord1: begin
				addrBit = 1'b0;
				wdata   = w1 | (8'h01 << `IVI_W1_INIT);
			end
			stWord2:   wdata = base;
			stCascade: wdata = cfgQ[`IVI_CFG_CASC];
			stModes:   wdata = cfgQ[`IVI_CFG_MODES];
			stMaskWr:  wdata = maskQ;
			stMaskRd:  kind  = kRead;
			stAck:     kind  = kAck;
		endcase
	end

	ivi_strobe #(
		.STROBE_CYC (STROBE_CYC),
		.RECOV_CYC  (RECOV_CYC)
	) uStrobe (
		.clk     (clk),
		.rstN    (rstNQ),
		.start   (start),
		.kind    (kind),
		.addrBit (addrBit),
		.wdata   (wdata),
		.done    (sDone),
		.rdata   (sData),
		.csB     (chipSelB),
		.wrB     (writeB),
		.rdB     (readB),
		.ackB    (irqAckStrobeB),
		.a0      (cmdSelectAddr),
		.dOut    (dataOut),
		.dOe     (dataOe),
		.dIn     (dataIn)
	);

	// ------------------------------------------------------------------
	// sequencer and apb registers
	// ------------------------------------------------------------------
	assign wrEn   = psel && penable && preadyQ && pwrite;
	assign mapped = (paddr == `IVI_OFF_CMD) || (paddr == `IVI_OFF_INIT) ||
		(paddr == `IVI_OFF_MASK) || (paddr == `IVI_OFF_STAT) ||
		(paddr == `IVI_OFF_VEC);

	always_comb begin
		stateD = stateQ; issuedD = issuedQ; initDoneD = initDoneQ;
		vecErrD = vecErrQ; ackIdxD = ackIdxQ; cfgD = cfgQ;
		maskD = maskQ; maskRdD = maskRdQ; vecD = vecQ;
		if (start)
			issuedD = 1'b1;
		if (sDone) begin
			issuedD = 1'b0;
			unique case (stateQ)
				stWord1: stateD = stWord2;
				stWord2:
					if (!w1[`IVI_W1_SINGLE_DEVICE_FLAG])
						stateD = stCascade;
					else if (w1[`IVI_W1_IC4])
						stateD = stModes;
					else
						stateD = stIdle;
				stCascade: stateD = w1[`IVI_W1_IC4] ? stModes : stIdle;
				stMaskRd: begin
					maskRdD = sData;
					stateD  = stIdle;
				end
				stAck: begin
					unique case (ackIdxQ)
						2'h0:    vecD[`IVI_VEC_B0] = sData;
						2'h1:    vecD[`IVI_VEC_B1] = sData;
						default: vecD[`IVI_VEC_B2] = sData;
					endcase
					if (!byteOk(ackIdxQ, sData))
						vecErrD = 1'b1;
					ackIdxD = ackIdxQ + 2'h1;
					if (ackIdxQ == lastAck)
						stateD = stIdle;
				end
				default: stateD = stIdle;
			endcase
			if ((stateD == stIdle) && (stateQ != stMaskWr) &&
				(stateQ != stMaskRd) && (stateQ != stAck))
				initDoneD = 1'b1;
		end
		if (wrEn && stateQ == stIdle) begin
			if (paddr == `IVI_OFF_INIT)
				cfgD = pwdata;
			if (paddr == `IVI_OFF_MASK)
				maskD = pwdata[7:0];
			if (paddr == `IVI_OFF_CMD) begin
				unique case (pwdata[`IVI_CMD_FLD])
					`IVI_CMD_INIT: begin
						initDoneD = 1'b0;
						stateD    = stWord1;
					end
					`IVI_CMD_MASKWR: if (initDoneQ)
						stateD = stMaskWr;
					`IVI_CMD_MASKRD: if (initDoneQ)
						stateD = stMaskRd;
					`IVI_CMD_ACK: if (initDoneQ) begin
						ackIdxD = 2'h0;
						vecErrD = 1'b0;
						vecD    = 24'h000000;
						stateD  = stAck;
					end
				endcase
			end
		end
	end

	always_comb begin
		preadyD = psel && !penable;
		slvErrD = psel && !penable && !mapped;
		prdataD = prdataQ;
		if (psel && !penable) begin
			prdataD = 32'h00000000;
			unique case (paddr)
				`IVI_OFF_INIT: prdataD = cfgQ;
				`IVI_OFF_MASK: prdataD[7:0] = maskQ;
				`IVI_OFF_STAT: begin
					prdataD[`IVI_ST_BUSY] = (stateQ != stIdle);
					prdataD[`IVI_ST_DONE] = initDoneQ;
					prdataD[`IVI_ST_VERR] = vecErrQ;
					prdataD[`IVI_ST_IRQ]  = irqS2Q;
					prdataD[`IVI_ST_MASK] = maskRdQ;
				end
				`IVI_OFF_VEC:  prdataD[23:0] = vecQ;
				default:       prdataD = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstNQ) begin
		if (!rstNQ) begin
			stateQ <= stIdle; issuedQ <= 1'b0; initDoneQ <= 1'b0;
			vecErrQ <= 1'b0; ackIdxQ <= 2'h0; cfgQ <= 32'h00000000;
			maskQ <= 8'h00; maskRdQ <= 8'h00; vecQ <= 24'h000000;
			prdataQ <= 32'h00000000; preadyQ <= 1'b0; slvErrQ <= 1'b0;
		end else begin
			stateQ <= stateD; issuedQ <= issuedD; initDoneQ <= initDoneD;
			vecErrQ <= vecErrD; ackIdxQ <= ackIdxD; cfgQ <= cfgD;
			maskQ <= maskD; maskRdQ <= maskRdD; vecQ <= vecD;
			prdataQ <= prdataD; preadyQ <= preadyD; slvErrQ <= slvErrD;
		end
	end

	assign prdata  = prdataQ;
	assign pready  = preadyQ;
	assign pslverr = slvErrQ;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstNQ);

	a_word1_format: assert property (start && stateQ == stWord1 |->
		!addrBit && wdata[`IVI_W1_INIT])
		else $error("first init word badly formed");
	a_base_follows: assert property (sDone && stateQ == stWord1 |=>
		stateQ == stWord2 && start && addrBit && wdata == base)
		else $error("vector base word not next");
	a_single_skip: assert property (sDone && stateQ == stWord2 &&
		w1[`IVI_W1_SINGLE_DEVICE_FLAG] |=> stateQ != stCascade)
		else $error("cascade word sent for single device");
	a_fourth_sent: assert property (sDone && w1[`IVI_W1_IC4] &&
		(stateQ == stCascade || (stateQ == stWord2 && w1[`IVI_W1_SINGLE_DEVICE_FLAG]))
		|=> stateQ == stModes)
		else $error("fourth init word skipped");
	a_ptr_two_acks: assert property (stateQ == stAck && ptrMode |->
		ackIdxQ <= 2'h1)
		else $error("too many acknowledges in pointer mode");
	a_opcode_check: assert property (sDone && stateQ == stAck &&
		!ptrMode && ackIdxQ == 2'h0 && sData != `IVI_CALL_OP |=> vecErrQ)
		else $error("bad call opcode not flagged");
	a_mask_refused: assert property (wrEn && paddr == `IVI_OFF_CMD &&
		!initDoneQ && stateQ == stIdle &&
		pwdata[`IVI_CMD_FLD] != `IVI_CMD_INIT |=>
		stateQ == stIdle)
		else $error("operation word before init done");
	a_apb_answer: assert property (psel && !penable |=> pready)
		else $error("apb answer not in access phase");

	c_init_full: cover property (sDone && stateQ == stModes);
	c_ack_call: cover property (sDone && stateQ == stAck && ackIdxQ == 2'h2);
	c_ack_ptr: cover property (sDone && stateQ == stAck && ptrMode &&
		ackIdxQ == 2'h1);
	c_mask_read: cover property (sDone && stateQ == stMaskRd);
endmodule

//--- verilog/ivi_strobe.sv
// one pin cycle to the device: write, status read or acknowledge
`include "ivi_map.svh"
module ivi_strobe
	import ivi_pkg::*;
#(
	parameter int STROBE_CYC = `IVI_STROBE_CYC,
	parameter int RECOV_CYC  = `IVI_RECOV_CYC
) (
	input  wire logic       clk,
	input  wire logic       rstN,
	input  wire logic       start,
	input  wire ivi_kind_t  kind,
	input  wire logic       addrBit,
	input  wire logic [7:0] wdata,
	output logic            done,
	output logic [7:0]      rdata,
	output logic            csB,
	output logic            wrB,
	output logic            rdB,
	output logic            ackB,
	output logic            a0,
	output logic [7:0]      dOut,
	output logic            dOe,
	input  wire logic [7:0] dIn
);
	localparam int StrobeW = STROBE_CYC;

	ivi_phase_t phQ, phD;
	ivi_kind_t  kindQ, kindD;
	logic [7:0] cntQ, cntD, rdQ, rdD, doQ, doD, s1Q, s2Q;
	logic       csQ, csD, wrQ, wrD, rdbQ, rdbD, akQ, akD;
	logic       a0Q, a0D, oeQ, oeD, doneQ, doneD;

	// ------------------------------------------------------------------
	// data pin synchroniser
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			s1Q <= 8'h00;
			s2Q <= 8'h00;
		end else begin
			s1Q <= dIn;
			s2Q <= s1Q;
		end
	end

	// ------------------------------------------------------------------
	// cycle sequencer
	// ------------------------------------------------------------------
	always_comb begin
		phD = phQ; kindD = kindQ; cntD = cntQ; rdD = rdQ; doD = doQ;
		csD = csQ; wrD = wrQ; rdbD = rdbQ; akD = akQ; a0D = a0Q;
		oeD = oeQ; doneD = 1'b0;
		unique case (phQ)
			phIdle: if (start) begin
				kindD = kind;
				a0D   = addrBit;
				doD   = wdata;
				csD   = (kind == kAck);
				oeD   = (kind == kWrite);
				phD   = phSetup;
			end
			phSetup: begin
				wrD  = !(kindQ == kWrite);
				rdbD = !(kindQ == kRead);
				akD  = !(kindQ == kAck);
				cntD = 8'(STROBE_CYC - 1);
				phD  = phStrobe;
			end
			phStrobe: if (cntQ == 8'h00) begin
				if (kindQ != kWrite)
					rdD = s2Q;
				wrD = 1'b1; rdbD = 1'b1; akD = 1'b1;
				csD = 1'b1; oeD = 1'b0;
				cntD = 8'(RECOV_CYC - 1);
				phD  = phRecov;
			end else begin
				cntD = cntQ - 8'h01;
			end
			phRecov: if (cntQ == 8'h00) begin
				doneD = 1'b1;
				phD   = phIdle;
			end else begin
				cntD = cntQ - 8'h01;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			phQ <= phIdle; kindQ <= kWrite; cntQ <= 8'h00;
			rdQ <= 8'h00; doQ <= 8'h00; csQ <= 1'b1; wrQ <= 1'b1;
			rdbQ <= 1'b1; akQ <= 1'b1; a0Q <= 1'b0; oeQ <= 1'b0;
			doneQ <= 1'b0;
		end else begin
			phQ <= phD; kindQ <= kindD; cntQ <= cntD; rdQ <= rdD;
			doQ <= doD; csQ <= csD; wrQ <= wrD; rdbQ <= rdbD;
			akQ <= akD; a0Q <= a0D; oeQ <= oeD; doneQ <= doneD;
		end
	end

	assign done  = doneQ;
	assign rdata = rdQ;
	assign csB   = csQ;
	assign wrB   = wrQ;
	assign rdB   = rdbQ;
	assign ackB  = akQ;
	assign a0    = a0Q;
	assign dOut  = doQ;
	assign dOe   = oeQ;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstN);

	a_write_width: assert property ($fell(wrB) |-> ##StrobeW $rose(wrB))
		else $error("write strobe width wrong");
	a_one_strobe: assert property ($onehot0({!wrB, !rdB, !ackB}))
		else $error("two strobes at once");
	a_ack_no_drive: assert property (!ackB |-> !dOe && csB)
		else $error("host drives data during acknowledge");
	a_done_single: assert property (done |=> !done)
		else $error("done longer than one cycle");
endmodule
